// >>> core/csw_pkg.sv
`default_nettype none
package csw_pkg;
	// Number of chip select outputs and register field layout.
	localparam int CSW_NUM_SEL = 4;
	localparam int CSW_CTL_IO_BIT = 4;
	localparam int CSW_CTL_EN_BIT = 3;
	localparam int CSW_CTL_WAIT_LO = 5;
	localparam int CSW_CTL_WAIT_HI = 7;
	localparam int CSW_MODE_CLK_LO = 0;
	localparam int CSW_MODE_CLK_HI = 3;
	localparam int CSW_MODE_FMT_LO = 4;
	localparam int CSW_MODE_FMT_HI = 5;

	// Byte offsets: each select owns a block of four words.
	localparam logic [7:0] CSW_OFF_CTL = 8'h00;
	localparam logic [7:0] CSW_OFF_LBR = 8'h04;
	localparam logic [7:0] CSW_OFF_UBR = 8'h08;
	localparam logic [7:0] CSW_OFF_MODE = 8'h0C;
	localparam logic [7:0] CSW_OFF_STATUS = 8'h40;

	// Reset values of the per-select registers.
	localparam logic [7:0] CSW_CTL0_RST = 8'h08;
	localparam logic [7:0] CSW_CTL_RST = 8'h00;
	localparam logic [7:0] CSW_LBR_RST = 8'h00;
	localparam logic [7:0] CSW_UBR0_RST = 8'hFF;
	localparam logic [7:0] CSW_UBR_RST = 8'h00;
	localparam logic [7:0] CSW_MODE_RST = 8'h01;

	// On-chip peripheral I/O window, compared on address bits 15:7.
	localparam logic [8:0] CSW_IO_ONCHIP = 9'h001;

	// AXI responses.
	localparam logic [1:0] CSW_RESP_OKAY = 2'h0;
	localparam logic [1:0] CSW_RESP_SLVERR = 2'h2;

	// Bus signal formats.
	typedef enum logic [1:0] {
		CSW_FMT_NATIVE = 2'h0,
		CSW_FMT_THREE = 2'h1,
		CSW_FMT_MUX = 2'h2,
		CSW_FMT_RSVD = 2'h3
	} csw_fmt_t;

	// Access sequencer states.
	typedef enum logic [5:0] {
		CSW_ST_IDLE = 6'b00_0001,
		CSW_ST_T1 = 6'b00_0010,
		CSW_ST_T2 = 6'b00_0100,
		CSW_ST_WAIT = 6'b00_1000,
		CSW_ST_T3 = 6'b01_0000,
		CSW_ST_DONE = 6'b10_0000
	} csw_state_t;
endpackage : csw_pkg
`default_nettype wire

// >>> core/csw_decoder.sv
// Behaviour
// - four selects, each memory or I/O only.
// - control bit 4 picks space, resets memory.
// - select asserts only with enable bit set.
// - memory match when lower<=A[23:16]<=upper.
// - lowest numbered matching select wins.
// - memory match drives select, memory request, strobe.
// - select 0 spans all; other bounds reset zero.
// - I/O match when A[15:8] equals lower bound.
// - I/O decode ignores upper byte, page base.
// - no I/O select for 0080h to 00FFh.
// - I/O match drives select, I/O request, strobe.
// - control bits 7:5 add zero to seven waits.
// - low wait input stalls until it rises.
// - decoding continues for granted external master.
// - per-select bus format and clocks per state.
// - every select defaults to native format.
// - three-state format: 1 to 15 clocks per state.
`default_nettype none
module csw_decoder
	import csw_pkg::*;
(
	// Clock and reset.
	input wire logic i_clock,
	input wire logic i_resetn,
	// AXI4-Lite register slave.
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	// CPU access request, same clock domain.
	input wire logic i_cpu_req,
	input wire logic [23:0] i_cpu_addr,
	input wire logic i_cpu_io,
	input wire logic i_cpu_write,
	input wire logic i_bus_grant_n,
	output logic o_cpu_done,
	// External master pins, sampled while the bus is granted.
	input wire logic [23:0] i_ext_addr,
	input wire logic i_ext_memory_request_n,
	input wire logic i_ext_io_request_n,
	input wire logic i_ext_read_n,
	input wire logic i_ext_write_n,
	// External wait pin.
	input wire logic i_wait_n,
	// Bus outputs.
	output logic o_select_0_n,
	output logic o_select_1_n,
	output logic o_select_2_n,
	output logic o_select_3_n,
	output logic o_memory_request_n,
	output logic o_io_request_n,
	output logic o_read_n,
	output logic o_write_n,
	output logic o_ale,
	output logic o_addr_on_data
);

	// Returns 1 when select i matches the given access.
	function automatic logic sel_match(input logic [7:0] ctl,
		input logic [7:0] lbr, input logic [7:0] ubr,
		input logic [23:0] addr, input logic is_io);
		logic hit;
		hit = 1'b0;
		if (ctl[CSW_CTL_EN_BIT]) begin
			if (ctl[CSW_CTL_IO_BIT]) begin
				// Bits 15:8 meet the lower bound, bits 15:7 the on-chip window; the upper byte is unused.
				hit = is_io && (addr[15:8] == lbr) &&
					(addr[15:7] != CSW_IO_ONCHIP);
			end else begin
				hit = !is_io && (addr[23:16] >= lbr) &&
					(addr[23:16] <= ubr);
			end
		end
		return hit;
	endfunction : sel_match

	// Per-select configuration registers.
	logic [7:0] ctl_r [CSW_NUM_SEL]; // Enable, space and wait count.
	logic [7:0] lbr_r [CSW_NUM_SEL]; // Lower bound.
	logic [7:0] ubr_r [CSW_NUM_SEL]; // Upper bound.
	logic [7:0] mode_r [CSW_NUM_SEL]; // Bus format and clocks per state.

	// AXI slave state.
	logic aw_held_r; // Write address taken and waiting.
	logic [7:0] aw_addr_r; // Captured write address.
	logic w_held_r; // Write data taken and waiting.
	logic [31:0] w_data_r; // Captured write data.
	logic [3:0] w_strb_r; // Captured byte enables.

	// Synchronisers for pins from outside the clock domain.
	logic wait_s1_r; // First stage, read by second stage only.
	logic wait_s2_r; // Usable wait level, low means stall.
	logic [27:0] ext_s1_r; // First stage of external master pins.
	logic [27:0] ext_s2_r; // Usable external master pins.

	// Sequencer state and latched access.
	csw_state_t state_r, state_nxt;
	logic [3:0] cnt_r; // Clocks left in the current bus state.
	logic [2:0] wcnt_r; // Programmed waits left.
	logic hit_r; // The access matched a select.
	logic [1:0] sel_r; // Index of the winning select.
	logic io_r; // The access is an I/O access.
	logic wr_r; // The access is a write.
	csw_fmt_t fmt_r; // Bus format of the winning select.
	logic [3:0] len_r; // Clocks per state of the winning select.
	logic [2:0] wst_r; // Wait count of the winning select.
	logic [3:0] sel_n_r; // Registered select outputs.

	// Live access request, from the CPU or the granted master.
	logic req_now, io_now, wr_now;
	logic [23:0] addr_now;
	logic dec_hit;
	logic [1:0] dec_sel;
	logic [3:0] dec_len;
	logic [2:0] dec_wst;
	csw_fmt_t dec_fmt;

	// Register writes happen when both address and data are held.
	logic wr_go;
	logic [1:0] wr_idx;
	assign wr_go = aw_held_r && w_held_r && !o_bvalid;
	assign wr_idx = aw_addr_r[5:4];

	// Pick the requester: the external master while granted.
	always_comb begin
		if (!i_bus_grant_n) begin
			addr_now = ext_s2_r[23:0];
			io_now = !ext_s2_r[25];
			wr_now = !ext_s2_r[27];
			req_now = (!ext_s2_r[24] || !ext_s2_r[25]) &&
				(!ext_s2_r[26] || !ext_s2_r[27]);
		end else begin
			addr_now = i_cpu_addr;
			io_now = i_cpu_io;
			wr_now = i_cpu_write;
			req_now = i_cpu_req;
		end
	end

	// Priority decode across the four selects.
	always_comb begin
		dec_hit = 1'b0;
		dec_sel = 2'h0;
		for (int i = CSW_NUM_SEL - 1; i >= 0; i--) begin
			if (sel_match(ctl_r[i], lbr_r[i], ubr_r[i], addr_now,
				io_now)) begin
				dec_hit = 1'b1;
				dec_sel = 2'(i);
			end
		end
		dec_fmt = csw_fmt_t'(mode_r[dec_sel][CSW_MODE_FMT_HI:
			CSW_MODE_FMT_LO]);
		dec_len = mode_r[dec_sel][CSW_MODE_CLK_HI:CSW_MODE_CLK_LO];
		if (dec_len == 4'h0) begin
			dec_len = 4'h1;
		end
		dec_wst = ctl_r[dec_sel][CSW_CTL_WAIT_HI:CSW_CTL_WAIT_LO];
	end

	// Two-flop synchronisers for the wait pin and master pins.
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			wait_s1_r <= 1'b1;
			wait_s2_r <= 1'b1;
			ext_s1_r <= 28'hFFF_FFFF;
			ext_s2_r <= 28'hFFF_FFFF;
		end else begin
			wait_s1_r <= i_wait_n;
			wait_s2_r <= wait_s1_r;
			ext_s1_r <= {i_ext_write_n, i_ext_read_n,
				i_ext_io_request_n, i_ext_memory_request_n, i_ext_addr};
			ext_s2_r <= ext_s1_r;
		end
	end

	// Next state of the access sequencer.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			CSW_ST_IDLE: begin
				if (req_now && !dec_hit) begin
					state_nxt = CSW_ST_DONE;
				end else if (req_now && dec_fmt == CSW_FMT_THREE) begin
					state_nxt = CSW_ST_T1;
				end else if (req_now && dec_fmt == CSW_FMT_MUX) begin
					state_nxt = CSW_ST_T1;
				end else if (req_now) begin
					state_nxt = CSW_ST_WAIT;
				end
			end
			CSW_ST_T1: begin
				if (cnt_r == 4'h0) begin
					state_nxt = CSW_ST_T2;
				end
			end
			CSW_ST_T2: begin
				if (cnt_r == 4'h0 && (wst_r != 3'h0 || !wait_s2_r)) begin
					state_nxt = CSW_ST_WAIT;
				end else if (cnt_r == 4'h0) begin
					state_nxt = CSW_ST_T3;
				end
			end
			CSW_ST_WAIT: begin
				// Leave only when waits are spent and the pin is high.
				if (wcnt_r == 3'h0 && wait_s2_r) begin
					state_nxt = (fmt_r == CSW_FMT_THREE ||
						fmt_r == CSW_FMT_MUX) ? CSW_ST_T3 : CSW_ST_DONE;
				end
			end
			CSW_ST_T3: begin
				if (cnt_r == 4'h0) begin
					state_nxt = CSW_ST_DONE;
				end
			end
			CSW_ST_DONE: begin
				// Hold until the request drops so it is not taken twice.
				if (!req_now) begin
					state_nxt = CSW_ST_IDLE;
				end
			end
			default: begin
				state_nxt = CSW_ST_IDLE;
			end
		endcase
	end

	// Sequencer state register.
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			state_r <= CSW_ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Latch the decoded access when it starts.
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			hit_r <= 1'b0;
			sel_r <= 2'h0;
			io_r <= 1'b0;
			wr_r <= 1'b0;
			fmt_r <= CSW_FMT_NATIVE;
			len_r <= 4'h1;
			wst_r <= 3'h0;
		end else if (state_r == CSW_ST_IDLE && req_now) begin
			hit_r <= dec_hit;
			sel_r <= dec_sel;
			io_r <= io_now;
			wr_r <= wr_now;
			fmt_r <= dec_fmt;
			len_r <= dec_len;
			wst_r <= dec_wst;
		end
	end

	// Clocks per bus state and programmed wait counters.
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			cnt_r <= 4'h0;
			wcnt_r <= 3'h0;
		end else begin
			if (state_r == CSW_ST_IDLE) begin
				cnt_r <= dec_len - 4'h1;
				wcnt_r <= dec_wst;
			end else if (state_nxt != state_r) begin
				cnt_r <= len_r - 4'h1;
			end else if (cnt_r != 4'h0) begin
				cnt_r <= cnt_r - 4'h1;
			end
			// The first WAIT clock counts as the first wait.
			if (state_r == CSW_ST_T2 && state_nxt == CSW_ST_WAIT) begin
				wcnt_r <= (wst_r == 3'h0) ? 3'h0 : wst_r - 3'h1;
			end else if (state_r == CSW_ST_WAIT && wcnt_r != 3'h0) begin
				wcnt_r <= wcnt_r - 3'h1;
			end
		end
	end

	// Bus pin outputs, registered from the next state.
	always_ff @(posedge i_clock) begin
		logic act;
		logic strb;
		logic hit;
		logic io;
		logic wr;
		logic [1:0] sel;
		csw_fmt_t fmt;
		act = 1'b0;
		strb = 1'b0;
		hit = (state_r == CSW_ST_IDLE) ? dec_hit : hit_r;
		io = (state_r == CSW_ST_IDLE) ? io_now : io_r;
		wr = (state_r == CSW_ST_IDLE) ? wr_now : wr_r;
		sel = (state_r == CSW_ST_IDLE) ? dec_sel : sel_r;
		fmt = (state_r == CSW_ST_IDLE) ? dec_fmt : fmt_r;
		if (!i_resetn) begin
			sel_n_r <= 4'hF;
			o_memory_request_n <= 1'b1;
			o_io_request_n <= 1'b1;
			o_read_n <= 1'b1;
			o_write_n <= 1'b1;
			o_ale <= 1'b0;
			o_addr_on_data <= 1'b0;
			o_cpu_done <= 1'b0;
		end else begin
			act = hit && (state_nxt == CSW_ST_T1 ||
				state_nxt == CSW_ST_T2 || state_nxt == CSW_ST_WAIT ||
				state_nxt == CSW_ST_T3);
			strb = act && state_nxt != CSW_ST_T1;
			sel_n_r <= act ? ~(4'h1 << sel) : 4'hF;
			o_memory_request_n <= !(strb && !io);
			o_io_request_n <= !(strb && io);
			o_read_n <= !(strb && !wr);
			o_write_n <= !(strb && wr);
			o_ale <= act && state_nxt == CSW_ST_T1 && fmt == CSW_FMT_MUX;
			o_addr_on_data <= act && state_nxt == CSW_ST_T1 &&
				fmt == CSW_FMT_MUX;
			o_cpu_done <= state_nxt == CSW_ST_DONE &&
				state_r != CSW_ST_DONE;
		end
	end

	assign o_select_0_n = sel_n_r[0];
	assign o_select_1_n = sel_n_r[1];
	assign o_select_2_n = sel_n_r[2];
	assign o_select_3_n = sel_n_r[3];

	// AXI write channels: address and data taken in either order.
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_held_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			o_bvalid <= 1'b0;
			o_bresp <= CSW_RESP_OKAY;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				w_held_r <= 1'b1;
				w_data_r <= i_wdata;
				w_strb_r <= i_wstrb;
			end
			if (wr_go) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp <= (aw_addr_r[7:6] == 2'h0 &&
					aw_addr_r[1:0] == 2'h0) ? CSW_RESP_OKAY : CSW_RESP_SLVERR;
			end else if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end

	// Ready is high while the matching holding slot is empty.
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			o_awready <= 1'b0;
			o_wready <= 1'b0;
		end else begin
			o_awready <= !aw_held_r && !(i_awvalid && o_awready);
			o_wready <= !w_held_r && !(i_wvalid && o_wready);
		end
	end

	// Configuration registers; byte lane 0 carries the data.
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			for (int i = 0; i < CSW_NUM_SEL; i++) begin
				ctl_r[i] <= (i == 0) ? CSW_CTL0_RST : CSW_CTL_RST;
				lbr_r[i] <= CSW_LBR_RST;
				ubr_r[i] <= (i == 0) ? CSW_UBR0_RST : CSW_UBR_RST;
				mode_r[i] <= CSW_MODE_RST;
			end
		end else if (wr_go && w_strb_r[0] && aw_addr_r[7:6] == 2'h0) begin
			case ({aw_addr_r[3:2], 2'h0})
				CSW_OFF_CTL[3:0]: ctl_r[wr_idx] <= w_data_r[7:0];
				CSW_OFF_LBR[3:0]: lbr_r[wr_idx] <= w_data_r[7:0];
				CSW_OFF_UBR[3:0]: ubr_r[wr_idx] <= w_data_r[7:0];
				CSW_OFF_MODE[3:0]: mode_r[wr_idx] <= w_data_r[7:0];
				default: begin
				end
			endcase
		end
	end

	// AXI read channel: one-cycle answer after the address is taken.
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= CSW_RESP_OKAY;
		end else begin
			o_arready <= !o_rvalid && !(i_arvalid && o_arready);
			if (i_arvalid && o_arready) begin
				o_rvalid <= 1'b1;
				o_rresp <= CSW_RESP_OKAY;
				o_rdata <= 32'h0000_0000;
				if (i_araddr[1:0] != 2'h0) begin
					o_rresp <= CSW_RESP_SLVERR;
				end else if (i_araddr == CSW_OFF_STATUS) begin
					// Live sequencer view for software.
					o_rdata <= {24'h00_0000, 1'b0, wr_r, io_r, hit_r,
						~(state_r == CSW_ST_IDLE), 1'b0, sel_r};
				end else if (i_araddr[7:6] == 2'h0) begin
					case ({i_araddr[3:2], 2'h0})
						CSW_OFF_CTL[3:0]: o_rdata[7:0] <= ctl_r[i_araddr[5:4]];
						CSW_OFF_LBR[3:0]: o_rdata[7:0] <= lbr_r[i_araddr[5:4]];
						CSW_OFF_UBR[3:0]: o_rdata[7:0] <= ubr_r[i_araddr[5:4]];
						default: o_rdata[7:0] <= mode_r[i_araddr[5:4]];
					endcase
				end else begin
					o_rresp <= CSW_RESP_SLVERR;
				end
			end else if (o_rvalid && i_rready) begin
				o_rvalid <= 1'b0;
			end
		end
	end

endmodule : csw_decoder
`default_nettype wire

// >>> tb/csw_chk.sv
`default_nettype none
module csw_chk (
	// Clock, reset and request pins.
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic i_cpu_req,
	input wire logic [23:0] i_cpu_addr,
	input wire logic i_cpu_io,
	input wire logic i_cpu_write,
	input wire logic i_bus_grant_n,
	input wire logic i_wait_n,
	// Bus outputs.
	input wire logic o_cpu_done,
	input wire logic o_select_0_n,
	input wire logic o_select_1_n,
	input wire logic o_select_2_n,
	input wire logic o_select_3_n,
	input wire logic o_memory_request_n,
	input wire logic o_io_request_n,
	input wire logic o_read_n,
	input wire logic o_write_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// Active-high view of the selects.
	logic [3:0] sel;
	// The CPU owns the bus and has an access out.
	logic cpu_on;
	assign sel = ~{o_select_3_n, o_select_2_n, o_select_1_n, o_select_0_n};
	assign cpu_on = i_bus_grant_n && i_cpu_req;
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_resetn);
	a_one_select: assert property ($onehot0(sel))
		else $error("two selects low at once");
	a_space_excl: assert property (o_memory_request_n || o_io_request_n)
		else $error("both request strobes low");
	a_dir_excl: assert property (o_read_n || o_write_n)
		else $error("read and write strobes low");
	a_req_select: assert property (
		!(o_memory_request_n && o_io_request_n) |-> sel != 4'h0)
		else $error("request strobe without a select");
	a_io_window: assert property (
		cpu_on && i_cpu_io && i_cpu_addr[15:7] == 9'h001 |-> sel == 4'h0)
		else $error("select in on-chip I/O window");
	a_done_idle: assert property (
		o_cpu_done |-> sel == 4'h0 && o_read_n && o_write_n)
		else $error("pins still low at done");
	a_idle_high: assert property (
		(i_bus_grant_n && !i_cpu_req) [*3] |-> sel == 4'h0)
		else $error("select low with no access");
	a_write_dir: assert property (
		cpu_on && !(o_read_n && o_write_n)
		|-> o_read_n == i_cpu_write && o_write_n == !i_cpu_write)
		else $error("strobe does not follow direction");
	a_space_dir: assert property (
		cpu_on && !(o_memory_request_n && o_io_request_n)
		|-> o_io_request_n == !i_cpu_io && o_memory_request_n == i_cpu_io)
		else $error("request strobe does not follow space");
	a_wait_hold: assert property (
		sel != 4'h0 && !i_wait_n && !$past(i_wait_n) && !$past(i_wait_n, 2)
		|=> !o_cpu_done)
		else $error("access ended while wait held low");
	c_io: cover property (!o_io_request_n);
	c_sel3: cover property (sel[3]);
	c_wait: cover property (sel != 4'h0 && !i_wait_n);
endmodule : csw_chk
bind csw_decoder csw_chk csw_chk_inst (.i_clock, .i_resetn, .i_cpu_req,
	.i_cpu_addr, .i_cpu_io, .i_cpu_write, .i_bus_grant_n, .i_wait_n,
	.o_cpu_done, .o_select_0_n, .o_select_1_n, .o_select_2_n,
	.o_select_3_n, .o_memory_request_n, .o_io_request_n, .o_read_n,
	.o_write_n);
`default_nettype wire

// >>> tb/csw_mem_model.sv
`default_nettype none
module csw_mem_model (
	// Pins seen by the peripheral.
	input wire logic i_clock,
	input wire logic i_select_n,
	input wire logic i_read_n,
	input wire logic i_write_n,
	// Extra cycles this peripheral asks for.
	input wire logic [3:0] i_stall,
	// Wait pin; driven high when not stalling.
	output logic o_wait_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// Cycles of wait still to hold, and access seen.
	logic [3:0] left_r = 4'h0;
	logic busy_r = 1'b0;
	// Load the stall count once per access, then count it down.
	always_ff @(posedge i_clock) begin
		if (!i_select_n && !(i_read_n && i_write_n)) begin
			busy_r <= 1'b1;
			if (!busy_r) begin
				left_r <= i_stall;
			end else if (left_r != 4'h0) begin
				left_r <= left_r - 4'h1;
			end
		end else begin
			busy_r <= 1'b0;
			left_r <= 4'h0;
		end
	end
	// Hold wait low until ready, then drive it high again.
	assign o_wait_n = !(busy_r && left_r != 4'h0);
endmodule : csw_mem_model
`default_nettype wire

// >>> tb/csw_decoder_tb.sv
`default_nettype none
module csw_decoder_tb
	import csw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Bench-driven inputs, named as the ports.
	logic i_clock, i_resetn, i_awvalid, i_wvalid, i_bready, i_arvalid;
	logic i_rready, i_cpu_req, i_cpu_io, i_cpu_write, i_bus_grant_n;
	logic i_ext_memory_request_n, i_ext_io_request_n, i_ext_read_n;
	logic i_ext_write_n, i_wait_n;
	logic [7:0] i_awaddr, i_araddr;
	logic [31:0] i_wdata;
	logic [3:0] i_wstrb, stall;
	logic [23:0] i_cpu_addr, i_ext_addr;
	// Design outputs.
	logic [31:0] o_rdata;
	logic [1:0] o_bresp, o_rresp;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_cpu_done;
	logic o_select_0_n, o_select_1_n, o_select_2_n, o_select_3_n;
	logic o_memory_request_n, o_io_request_n, o_read_n, o_write_n;
	logic o_ale, o_addr_on_data;
	logic [3:0] sel;
	// Counts, last access length and address-phase cycles seen.
	int miscompares, check_count, l, ale;
	assign sel = ~{o_select_3_n, o_select_2_n, o_select_1_n, o_select_0_n};
	csw_decoder csw_decoder_inst (.i_clock, .i_resetn, .i_awaddr,
		.i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready,
		.o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
		.o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_cpu_req, .i_cpu_addr,
		.i_cpu_io, .i_cpu_write, .i_bus_grant_n, .o_cpu_done, .i_ext_addr,
		.i_ext_memory_request_n, .i_ext_io_request_n, .i_ext_read_n,
		.i_ext_write_n, .i_wait_n, .o_select_0_n, .o_select_1_n,
		.o_select_2_n, .o_select_3_n, .o_memory_request_n, .o_io_request_n,
		.o_read_n, .o_write_n, .o_ale, .o_addr_on_data);
	// The slow peripheral sits behind select 2.
	csw_mem_model csw_mem_model_inst (.i_clock, .i_select_n(o_select_2_n),
		.i_read_n(o_read_n), .i_write_n(o_write_n), .i_stall(stall),
		.o_wait_n(i_wait_n));
	// Counts and closes the run.
	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : print_verdict
	// A wait that ran out of bound.
	task automatic hang();
		miscompares++;
		print_verdict();
	endtask : hang
	// Compare one value and count it.
	task automatic check(input logic [31:0] got, exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	// Register write: address and data offered together.
	task automatic axw(input logic [7:0] a, d, input logic [1:0] er);
		int n;
		@(posedge i_clock);
		i_awaddr <= a;
		i_wdata <= {24'h00_0000, d};
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge i_clock);
			if (o_awready === 1'b1) i_awvalid <= 1'b0;
			if (o_wready === 1'b1) i_wvalid <= 1'b0;
			if (o_bvalid === 1'b1) break;
		end
		if (n == 64) hang();
		i_bready <= 1'b0;
		check(o_bresp, er);
	endtask : axw
	// Register read, compared against the expected byte.
	task automatic axr(input logic [7:0] a, d, input logic [1:0] er);
		int n;
		@(posedge i_clock);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge i_clock);
			if (o_arready === 1'b1) i_arvalid <= 1'b0;
			if (o_rvalid === 1'b1) break;
		end
		if (n == 64) hang();
		i_rready <= 1'b0;
		check(o_rdata, {24'h00_0000, d});
		check(o_rresp, er);
	endtask : axr
	// Control, lower and upper bound of one select.
	task automatic cfg(input int s, input logic [7:0] c, lo, hi);
		axw(8'(16 * s) + CSW_OFF_CTL, c, CSW_RESP_OKAY);
		axw(8'(16 * s) + CSW_OFF_LBR, lo, CSW_RESP_OKAY);
		axw(8'(16 * s) + CSW_OFF_UBR, hi, CSW_RESP_OKAY);
	endtask : cfg
	// One access by CPU or external master; checks selects and length.
	task automatic ac(input logic [23:0] a, input logic io, wr, ext,
		input logic [3:0] es, input int el, output int len);
		int n;
		logic [3:0] seen;
		seen = 4'h0;
		len = 0;
		@(posedge i_clock);
		i_ext_addr <= a;
		i_cpu_addr <= a;
		i_cpu_io <= io;
		i_cpu_write <= wr;
		i_cpu_req <= !ext;
		i_ext_memory_request_n <= !ext || io;
		i_ext_io_request_n <= !ext || !io;
		i_ext_read_n <= !ext || wr;
		i_ext_write_n <= !ext || !wr;
		for (n = 0; n < 200; n++) begin
			@(posedge i_clock);
			#1;
			seen |= sel;
			len += int'(sel != 4'h0);
			ale += int'(o_ale) + int'(o_addr_on_data);
			if (o_cpu_done === 1'b1) break;
		end
		if (n == 200) hang();
		@(posedge i_clock);
		i_cpu_req <= 1'b0;
		i_ext_memory_request_n <= 1'b1;
		i_ext_io_request_n <= 1'b1;
		i_ext_read_n <= 1'b1;
		i_ext_write_n <= 1'b1;
		repeat (4) @(posedge i_clock);
		check(seen, es);
		if (el >= 0) check(len, el);
	endtask : ac
	// Reset contents, refused addresses, first decode.
	task automatic t_reset();
		axr(CSW_OFF_CTL, 8'h08, CSW_RESP_OKAY);
		axr(CSW_OFF_UBR, 8'hFF, CSW_RESP_OKAY);
		axr(CSW_OFF_LBR, 8'h00, CSW_RESP_OKAY);
		axr(8'h38, 8'h00, CSW_RESP_OKAY);
		axr(8'h1C, 8'h01, CSW_RESP_OKAY);
		axr(8'h44, 8'h00, CSW_RESP_SLVERR);
		axr(8'h05, 8'h00, CSW_RESP_SLVERR);
		axw(8'h44, 8'h55, CSW_RESP_SLVERR);
		ac(24'hAB_CDEF, 0, 0, 0, 4'h1, 1, l);
		ac(24'h00_1234, 1, 1, 0, 4'h0, 0, l);
	endtask : t_reset
	// Range bounds, overlap priority and enable.
	task automatic t_memory();
		cfg(0, 8'h08, 8'h00, 8'h7F);
		cfg(1, 8'h08, 8'h00, 8'h9F);
		cfg(2, 8'h08, 8'hA0, 8'hA0);
		axr(8'h18, 8'h9F, CSW_RESP_OKAY);
		ac(24'h7F_FFFF, 0, 1, 0, 4'h1, 1, l);
		ac(24'h80_0000, 0, 0, 0, 4'h2, 1, l);
		ac(24'hA0_FFFF, 0, 1, 0, 4'h4, 1, l);
		ac(24'hA1_0000, 0, 0, 0, 4'h0, 0, l);
		cfg(2, 8'h00, 8'hA0, 8'hA0);
		ac(24'hA0_0000, 0, 0, 0, 4'h0, 0, l);
	endtask : t_memory
	// I/O match, ignored upper byte, on-chip window.
	task automatic t_io();
		cfg(3, 8'h18, 8'h12, 8'h00);
		ac(24'hFF_1234, 1, 0, 0, 4'h8, 1, l);
		ac(24'hB0_1234, 0, 0, 0, 4'h0, 0, l);
		ac(24'h00_1334, 1, 1, 0, 4'h0, 0, l);
		cfg(3, 8'h18, 8'h00, 8'h00);
		ac(24'h00_0080, 1, 0, 0, 4'h0, 0, l);
		ac(24'h00_00FF, 1, 1, 0, 4'h0, 0, l);
		ac(24'h00_007F, 1, 0, 0, 4'h8, 1, l);
		cfg(1, 8'h18, 8'h00, 8'h00);
		ac(24'h00_0040, 1, 0, 0, 4'h2, 1, l);
	endtask : t_io
	// Every programmed wait count, then a stalling peripheral.
	task automatic t_waits();
		for (int w = 0; w < 8; w++) begin
			cfg(2, {w[2:0], 5'h08}, 8'hA0, 8'hA0);
			ac(24'hA0_0010, 0, w[0], 0, 4'h4, w + 1, l);
		end
		stall <= 4'hC;
		ac(24'hA0_0000, 0, 1, 0, 4'h4, -1, l);
		check(32'(l > 12 && l < 18), 32'h0000_0001);
		stall <= 4'h0;
	endtask : t_waits
	// External master holds the bus; decoding goes on.
	task automatic t_ext();
		cfg(2, 8'h08, 8'hA0, 8'hA0);
		i_bus_grant_n <= 1'b0;
		ac(24'hA0_5555, 0, 0, 1, 4'h4, -1, l);
		ac(24'h00_0040, 1, 1, 1, 4'h2, -1, l);
		i_bus_grant_n <= 1'b1;
	endtask : t_ext
	// Three-state and multiplexed formats, masked write, status word.
	task automatic t_modes();
		cfg(2, 8'h28, 8'hA0, 8'hA0);
		axw(8'h20 + CSW_OFF_MODE, 8'h12, CSW_RESP_OKAY);
		axr(8'h20 + CSW_OFF_MODE, 8'h12, CSW_RESP_OKAY);
		ale = 0;
		// Two clocks per state: T1, T2, T3 and one programmed wait.
		ac(24'hA0_0000, 0, 0, 0, 4'h4, 7, l);
		check(ale, 32'h0000_0000);
		axw(8'h20 + CSW_OFF_MODE, 8'h21, CSW_RESP_OKAY);
		// A write with byte lane 0 masked must leave the control alone.
		i_wstrb <= 4'h0;
		axw(8'h20, 8'h00, CSW_RESP_OKAY);
		i_wstrb <= 4'h1;
		axr(8'h20, 8'h28, CSW_RESP_OKAY);
		ale = 0;
		ac(24'hA0_0000, 0, 1, 0, 4'h4, 4, l);
		check(ale, 32'h0000_0002);
		// Last access: write, memory, hit, select 2, sequencer idle.
		axr(CSW_OFF_STATUS, 8'h52, CSW_RESP_OKAY);
	endtask : t_modes
	// Free-running clock.
	initial begin
		i_clock = 1'b0;
		forever #10 i_clock = ~i_clock;
	end
	// Main sequence.
	initial begin
		{i_resetn, i_awvalid, i_wvalid, i_bready, i_arvalid} = '0;
		{i_rready, i_cpu_req, i_cpu_io, i_cpu_write} = '0;
		{i_awaddr, i_araddr, i_wdata, i_cpu_addr, i_ext_addr} = '0;
		{i_ext_memory_request_n, i_ext_io_request_n} = 2'h3;
		{i_ext_read_n, i_ext_write_n, i_bus_grant_n} = 3'h7;
		i_wstrb = 4'h1;
		stall = 4'h0;
		repeat (8) @(posedge i_clock);
		i_resetn <= 1'b1;
		repeat (2) @(posedge i_clock);
		t_reset();
		t_memory();
		t_io();
		t_waits();
		t_ext();
		t_modes();
		print_verdict();
	end
endmodule : csw_decoder_tb
`default_nettype wire
